// ==== rtl/cabbo_cfg.svh ====
/*
 * Constants of the arithmetic, bit and branch execution block: register byte
 * offsets, command field positions and widths.
 * Assumes a classic Wishbone master with 32-bit data and byte addresses.
 */
// What this block does
// - add immediate to accumulator, result in accumulator
// - and accumulator with file, destination bit picks target
// - add accumulator and file, destination bit picks target
// - shift file right, msb kept, lsb to carry
// - add accumulator, carry flag and file register
// - clear one file bit, nothing else changes
// - skip next instruction when tested bit zero
// - jump to pc plus one plus signed offset
// - relative jump always takes two cycles
// - add with carry updates c, dc, z; dest selects
// - pc change or true test adds nop cycle
`ifndef CABBO_CFG_SVH
`define CABBO_CFG_SVH
`define CABBO_ADR_CMD   8'h00
`define CABBO_ADR_ACC   8'h04
`define CABBO_ADR_STAT  8'h08
`define CABBO_ADR_PC    8'h0C
`define CABBO_ADR_FPTR  8'h10
`define CABBO_ADR_FDATA 8'h14
`define CABBO_F_OP      3:0
`define CABBO_F_DEST    4
`define CABBO_F_BIT     7:5
`define CABBO_F_FADR    14:8
`define CABBO_F_IMM     24:16
`define CABBO_IMM8      7:0
`define CABBO_S_C       0
`define CABBO_S_DC      1
`define CABBO_S_Z       2
`define CABBO_S_BUSY    8
`define CABBO_DW        8
`define CABBO_MSB       7
`define CABBO_LSB       0
`define CABBO_NIB       3:0
`define CABBO_NIB_CY    4
`define CABBO_FILE_N    128
`define CABBO_FA_W      7
`define CABBO_PC_W      15
`define CABBO_IMM_W     9
`define CABBO_LANES     4
`define CABBO_LANE_W    8
`endif

// ==== rtl/cabbo_pkg.sv ====
/*
 * Types of the execution block: operation codes, sequencing phases, the
 * decoded command and the whole block state.
 * Assumes cabbo_cfg.svh is on the include path.
 */
`include "cabbo_cfg.svh"
package cabbo_pkg;
    typedef enum logic [3:0] {
        OP_ADD_IMM, OP_AND_FILE, OP_ADD_FILE, OP_ADDC_FILE, OP_ASR_FILE,
        OP_CLR_BIT, OP_TEST_SKIP_ZERO, OP_REL_JUMP, OP_NOP
    } cabbo_op_e;
    typedef enum logic [1:0] {PH_RUN, PH_SKIP, PH_JUMP} cabbo_phase_e;
    typedef struct packed {
        logic [`CABBO_IMM_W-1:0] imm;
        logic [`CABBO_FA_W-1:0]  fadr;
        logic [2:0]              bitsel;
        logic                    dest;
        cabbo_op_e               op;
    } cabbo_insn_s;
    typedef struct packed {
        logic [`CABBO_FILE_N-1:0][`CABBO_DW-1:0] fmem;
        logic [`CABBO_PC_W-1:0]                  pc;
        logic [`CABBO_DW-1:0]                    acc;
        logic                                    c;
        logic                                    dc;
        logic                                    z;
        logic [`CABBO_FA_W-1:0]                  fptr;
        logic                                    ack;
        logic [31:0]                             dat;
        cabbo_phase_e                            phase;
        logic                                    busy;
    } cabbo_state_s;
endpackage

// ==== rtl/cabbo_core.sv ====
/*
 * Execution core for add, and, shift, bit clear, bit test with skip and the
 * relative jump, with its file registers, accumulator, flags and pc.
 * Assumes a classic Wishbone master; one bus command is one instruction.
 */
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "cabbo_cfg.svh"
module cabbo_core
    import cabbo_pkg::*;
(
    input  wire logic                   I_CLK,
    input  wire logic                   I_SYS_RST,
    input  wire logic                   I_WB_CYC,
    input  wire logic                   I_WB_STB,
    input  wire logic                   I_WB_WE,
    input  wire logic [7:0]             I_WB_ADR,
    input  wire logic [3:0]             I_WB_SEL,
    input  wire logic [31:0]            I_WB_DAT,
    output logic      [31:0]            O_WB_DAT,
    output logic                        O_WB_ACK,
    output logic      [`CABBO_PC_W-1:0] O_PC,
    output logic      [`CABBO_DW-1:0]   O_ACC,
    output logic                        O_BUSY
);

    cabbo_state_s              st;
    cabbo_state_s              next_st;
    cabbo_insn_s               insn;
    logic                      req;
    logic                      cmd_wr;
    logic                      go;
    logic [`CABBO_DW-1:0]      fval;
    logic [`CABBO_DW-1:0]      opnd;
    logic                      cin;
    logic [`CABBO_DW:0]        sum;
    logic [`CABBO_NIB_CY:0]    hsum;
    logic [`CABBO_DW-1:0]      res;
    logic [`CABBO_PC_W-1:0]    jofs;
    logic [31:0]               wdat;
    logic [31:0]               rdat;
    logic [31:0]               mrg;

    // byte lanes not selected keep their old content
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        logic [31:0] m;
        m = old_v;
        for (int i = 0; i < `CABBO_LANES; i++)
        begin
            if (sel[i])
            begin
                m[i*`CABBO_LANE_W +: `CABBO_LANE_W] = new_v[i*`CABBO_LANE_W +: `CABBO_LANE_W];
            end
        end
        return m;
    endfunction

    assign req    = I_WB_CYC & I_WB_STB & ~st.ack;
    assign cmd_wr = req & I_WB_WE & (I_WB_ADR == `CABBO_ADR_CMD);
    // a command is held off, not dropped, while the nop cycle runs
    assign go     = cmd_wr & (st.phase == PH_RUN);
    assign wdat   = merge(32'h0000_0000, I_WB_DAT, I_WB_SEL);
    // the read view of the addressed register is the old value under a partial write
    assign mrg    = merge(rdat, I_WB_DAT, I_WB_SEL);

    always_comb
    begin
        insn.op     = cabbo_op_e'(wdat[`CABBO_F_OP]);
        insn.dest   = wdat[`CABBO_F_DEST];
        insn.bitsel = wdat[`CABBO_F_BIT];
        insn.fadr   = wdat[`CABBO_F_FADR];
        insn.imm    = wdat[`CABBO_F_IMM];
    end

    assign fval = st.fmem[insn.fadr];
    assign opnd = (insn.op == OP_ADD_IMM) ? insn.imm[`CABBO_IMM8] : fval;
    assign cin  = (insn.op == OP_ADDC_FILE) ? st.c : 1'b0;
    assign sum  = {1'b0, st.acc} + {1'b0, opnd} + {`CABBO_DW'(0), cin};
    assign hsum = {1'b0, st.acc[`CABBO_NIB]} + {1'b0, opnd[`CABBO_NIB]}
                + {4'h0, cin};
    // offsets outside -256..255 cannot be encoded in the 9-bit field
    assign jofs = `CABBO_PC_W'($signed(insn.imm));

    always_comb
    begin
        unique case (I_WB_ADR)
            `CABBO_ADR_ACC:   rdat = {24'h00_0000, st.acc};
            `CABBO_ADR_STAT:  rdat = {23'h00_0000, st.busy, 5'h00, st.z, st.dc, st.c};
            `CABBO_ADR_PC:    rdat = {17'h0_0000, st.pc};
            `CABBO_ADR_FPTR:  rdat = {25'h000_0000, st.fptr};
            `CABBO_ADR_FDATA: rdat = {24'h00_0000, st.fmem[st.fptr]};
            default:          rdat = 32'h0000_0000;
        endcase
    end

    always_comb
    begin
        next_st     = st;
        res         = `CABBO_DW'(0);
        next_st.ack = req & ~(cmd_wr & ~go);
        next_st.dat = (req & ~I_WB_WE) ? rdat : 32'h0000_0000;
        unique case (st.phase)
            PH_RUN:
            begin
                if (go)
                begin
                    next_st.pc = st.pc + `CABBO_PC_W'(1);
                    case (insn.op)
                        OP_ADD_IMM, OP_ADD_FILE, OP_ADDC_FILE:
                        begin
                            res        = sum[`CABBO_DW-1:0];
                            next_st.c  = sum[`CABBO_DW];
                            next_st.dc = hsum[`CABBO_NIB_CY];
                            next_st.z  = (res == `CABBO_DW'(0));
                            if (insn.op != OP_ADD_IMM && insn.dest)
                            begin
                                next_st.fmem[insn.fadr] = res;
                            end
                            else
                            begin
                                next_st.acc = res;
                            end
                        end
                        OP_AND_FILE:
                        begin
                            res       = st.acc & fval;
                            next_st.z = (res == `CABBO_DW'(0));
                            if (insn.dest)
                            begin
                                next_st.fmem[insn.fadr] = res;
                            end
                            else
                            begin
                                next_st.acc = res;
                            end
                        end
                        OP_ASR_FILE:
                        begin
                            res       = {fval[`CABBO_MSB], fval[`CABBO_MSB:1]};
                            next_st.c = fval[`CABBO_LSB];
                            next_st.z = (res == `CABBO_DW'(0));
                            if (insn.dest)
                            begin
                                next_st.fmem[insn.fadr] = res;
                            end
                            else
                            begin
                                next_st.acc = res;
                            end
                        end
                        OP_CLR_BIT:
                        begin
                            next_st.fmem[insn.fadr][insn.bitsel] = 1'b0;
                        end
                        OP_TEST_SKIP_ZERO:
                        begin
                            if (!fval[insn.bitsel])
                            begin
                                next_st.phase = PH_SKIP;
                            end
                        end
                        OP_REL_JUMP:
                        begin
                            next_st.pc    = st.pc + `CABBO_PC_W'(1) + jofs;
                            next_st.phase = PH_JUMP;
                        end
                        default:
                        begin
                            next_st.phase = PH_RUN;
                        end
                    endcase
                end
                else if (req & I_WB_WE)
                begin
                    unique case (I_WB_ADR)
                        `CABBO_ADR_ACC:
                            next_st.acc = mrg[`CABBO_DW-1:0];
                        `CABBO_ADR_STAT:
                        begin
                            next_st.c  = mrg[`CABBO_S_C];
                            next_st.dc = mrg[`CABBO_S_DC];
                            next_st.z  = mrg[`CABBO_S_Z];
                        end
                        `CABBO_ADR_PC:
                            next_st.pc = mrg[`CABBO_PC_W-1:0];
                        `CABBO_ADR_FPTR:
                            next_st.fptr = mrg[`CABBO_FA_W-1:0];
                        `CABBO_ADR_FDATA:
                            next_st.fmem[st.fptr] = mrg[`CABBO_DW-1:0];
                        default:
                            next_st.fptr = st.fptr;
                    endcase
                end
            end
            PH_SKIP:
            begin
                // the discarded instruction still uses its slot
                next_st.pc    = st.pc + `CABBO_PC_W'(1);
                next_st.phase = PH_RUN;
            end
            PH_JUMP:
            begin
                next_st.phase = PH_RUN;
            end
        endcase
        next_st.busy = (next_st.phase != PH_RUN);
    end

    // file registers and pc clear with everything else at reset
    always_ff @(posedge I_CLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign O_WB_DAT = st.dat;
    assign O_WB_ACK = st.ack;
    assign O_PC     = st.pc;
    assign O_ACC    = st.acc;
    assign O_BUSY   = st.busy;

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_SYS_RST);

    a_add_imm_acc: assert property (
        go && insn.op == OP_ADD_IMM |=>
            st.acc == $past(st.acc) + $past(insn.imm[`CABBO_IMM8]))
        else $error("immediate add result wrong");
    a_add_flag_set: assert property (
        go && insn.op == OP_ADD_IMM |=>
            st.z == (st.acc == `CABBO_DW'(0))
            && st.c == (9'($past(st.acc)) + 9'($past(insn.imm[`CABBO_IMM8])) > 9'h0FF)
            && st.dc == (5'($past(st.acc[`CABBO_NIB])) + 5'($past(insn.imm[`CABBO_NIB]))
                         > 5'h0F))
        else $error("add flags wrong");
    a_and_acc_dest: assert property (
        go && insn.op == OP_AND_FILE && !insn.dest |=>
            st.acc == ($past(st.acc) & $past(fval)))
        else $error("and result wrong");
    a_and_keep_carry: assert property (
        go && insn.op == OP_AND_FILE |=> st.c == $past(st.c) && st.dc == $past(st.dc))
        else $error("and changed a carry flag");
    a_add_file_dest: assert property (
        go && insn.op == OP_ADD_FILE && insn.dest |=>
            st.fmem[$past(insn.fadr)] == $past(st.acc) + $past(fval)
            && st.acc == $past(st.acc))
        else $error("file add target wrong");
    a_shift_msb_kept: assert property (
        go && insn.op == OP_ASR_FILE && !insn.dest |=>
            st.acc[`CABBO_MSB] == $past(fval[`CABBO_MSB])
            && st.c == $past(fval[`CABBO_LSB]) && st.dc == $past(st.dc))
        else $error("arithmetic shift wrong");
    a_addc_sum_carry: assert property (
        go && insn.op == OP_ADDC_FILE && !insn.dest |=>
            {st.c, st.acc} == {1'b0, $past(st.acc)} + {1'b0, $past(fval)}
            + {`CABBO_DW'(0), $past(st.c)})
        else $error("add with carry wrong");
    a_clr_bit_only: assert property (
        go && insn.op == OP_CLR_BIT |=>
            !st.fmem[$past(insn.fadr)][$past(insn.bitsel)] && $stable({st.c, st.dc, st.z}))
        else $error("bit clear wrong");
    a_skip_two_cyc: assert property (
        go && insn.op == OP_TEST_SKIP_ZERO && !fval[insn.bitsel] |=>
            st.busy ##1 (!st.busy && st.pc == $past(st.pc, 2) + `CABBO_PC_W'(2)))
        else $error("skip did not take two cycles");
    a_no_skip_one: assert property (
        go && insn.op == OP_TEST_SKIP_ZERO && fval[insn.bitsel] |=>
            !st.busy && st.pc == $past(st.pc) + `CABBO_PC_W'(1))
        else $error("test with bit set did not fall through");
    a_jump_target: assert property (
        go && insn.op == OP_REL_JUMP |=>
            st.busy && st.pc == $past(st.pc) + `CABBO_PC_W'(1) + $past(jofs)
            ##1 !st.busy && $stable(st.pc))
        else $error("relative jump wrong");
    // operands are looked at one cycle back, as the instruction has updated acc and the file registers by then
    a_and_zero_flag: assert property (
        go && insn.op == OP_AND_FILE |=>
            st.z == (($past(st.acc) & $past(fval)) == `CABBO_DW'(0)))
        else $error("and zero flag wrong");
    a_shift_file_dest: assert property (
        go && insn.op == OP_ASR_FILE && insn.dest |=>
            st.fmem[$past(insn.fadr)] == {$past(fval[`CABBO_MSB]), $past(fval[`CABBO_MSB:1])}
            && st.acc == $past(st.acc))
        else $error("shift to file wrong");
    a_addc_file_dest: assert property (
        go && insn.op == OP_ADDC_FILE && insn.dest |=>
            st.fmem[$past(insn.fadr)] == $past(st.acc) + $past(fval) + $past(st.c)
            && st.acc == $past(st.acc))
        else $error("add with carry target wrong");
    a_clr_other_bits: assert property (
        go && insn.op == OP_CLR_BIT |=>
            st.fmem[$past(insn.fadr)] == ($past(fval) & ~(8'h01 << $past(insn.bitsel)))
            && $stable(st.acc))
        else $error("bit clear touched other bits");
    a_test_flags_kept: assert property (
        go && insn.op == OP_TEST_SKIP_ZERO |=> $stable({st.c, st.dc, st.z}))
        else $error("bit test changed a flag");
    a_jump_flags_kept: assert property (
        go && insn.op == OP_REL_JUMP |=> $stable({st.c, st.dc, st.z}))
        else $error("relative jump changed a flag");

endmodule
`default_nettype wire

// ==== testbench/cabbo_host.sv ====
/*
 * Classic Wishbone master standing in for the software side of the block.
 * Assumes one clock; transfers are requested from one process at a time.
 */
`timescale 1ns/100ps
`default_nettype none
module cabbo_host (
    input  wire logic        i_clk,
    input  wire logic        i_ack,
    input  wire logic [31:0] i_dat,
    input  wire logic        i_busy,
    output logic             o_cyc,
    output logic             o_stb,
    output logic             o_we,
    output logic [7:0]       o_adr,
    output logic [3:0]       o_sel,
    output logic [31:0]      o_dat
);
    logic busy_ack;
    initial
    begin
        o_cyc = 1'b0;
        o_stb = 1'b0;
        o_we = 1'b0;
        o_adr = 8'h00;
        o_sel = 4'h0;
        o_dat = 32'h0;
        busy_ack = 1'b0;
    end
    // no fixed latency assumed: the bench timeout ends a hung wait
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      output logic [31:0] rdat);
        @(posedge i_clk);
        o_cyc <= 1'b1;
        o_stb <= 1'b1;
        o_we <= we;
        o_adr <= adr;
        o_sel <= 4'hF;
        o_dat <= dat;
        @(posedge i_clk);
        while (i_ack !== 1'b1)
            @(posedge i_clk);
        rdat = i_dat;
        busy_ack = i_busy;
        o_cyc <= 1'b0;
        o_stb <= 1'b0;
        o_we <= 1'b0;
        // released lines must not keep looking valid
        o_adr <= ~adr;
        o_dat <= ~dat;
    endtask
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
/*
 * Self-checking bench of the execution block: instructions as bus commands.
 * Assumes the host model drives the bus and the package holds the op codes.
 */
`timescale 1ns/100ps
`default_nettype none
`include "cabbo_cfg.svh"
module tb
    import cabbo_pkg::*;
;
    logic        clk, rst, cyc, stb, we, ack, busy;
    logic [7:0]  adr, acc, exp_acc, v;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat;
    logic [14:0] pc, exp_pc;
    int          n_errors, checks, cyc_cnt;
    int          offs [4] = '{-256, 255, 0, -1};
    cabbo_core cabbo_core_inst (.I_CLK(clk), .I_SYS_RST(rst), .I_WB_CYC(cyc),
        .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat),
        .O_WB_DAT(rdat), .O_WB_ACK(ack), .O_PC(pc), .O_ACC(acc), .O_BUSY(busy));
    cabbo_host cabbo_host_inst (.i_clk(clk), .i_ack(ack), .i_dat(rdat), .i_busy(busy),
        .o_cyc(cyc), .o_stb(stb), .o_we(we), .o_adr(adr), .o_sel(sel), .o_dat(wdat));
    task automatic test_done;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        cabbo_host_inst.wb(1'b1, a, d, r);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
        logic [31:0] r;
        cabbo_host_inst.wb(1'b0, a, 32'h0, r);
        chk(nm, e, r);
    endtask
    task automatic setf(input logic [6:0] f, input logic [7:0] d);
        wr(`CABBO_ADR_FPTR, {25'h0, f});
        wr(`CABBO_ADR_FDATA, {24'h0, d});
    endtask
    task automatic chkf(input logic [6:0] f, input logic [7:0] d);
        wr(`CABBO_ADR_FPTR, {25'h0, f});
        rdc(`CABBO_ADR_FDATA, {24'h0, d}, "file");
    endtask
    task automatic setacc(input logic [7:0] d);
        wr(`CABBO_ADR_ACC, {24'h0, d});
        exp_acc = d;
    endtask
    // one command; pc, acc and the nop cycle are checked when it has settled
    task automatic cmd(input cabbo_op_e op, input logic d, input logic [2:0] b,
                       input logic [6:0] f, input logic [8:0] k, input int adv,
                       input logic bz);
        logic [31:0] r;
        cabbo_host_inst.wb(1'b1, `CABBO_ADR_CMD, {7'h00, k, 1'b0, f, b, d, op}, r);
        chk("busy at ack", {31'h0, bz}, {31'h0, cabbo_host_inst.busy_ack});
        @(posedge clk);
        exp_pc = exp_pc + 15'(adv);
        chk("pc", {17'h0, exp_pc}, {17'h0, pc});
        chk("acc", {24'h0, exp_acc}, {24'h0, acc});
        chk("busy", 32'h0, {31'h0, busy});
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 4000)
        begin
            n_errors++;
            test_done;
        end
    end
    initial
    begin
        rst = 1'b1;
        n_errors = 0;
        checks = 0;
        cyc_cnt = 0;
        exp_pc = 15'h0;
        exp_acc = 8'h00;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rdc(`CABBO_ADR_ACC, 32'h0, "acc reset");
        rdc(`CABBO_ADR_STAT, 32'h0, "stat reset");
        rdc(`CABBO_ADR_PC, 32'h0, "pc reset");
        rdc(`CABBO_ADR_CMD, 32'h0, "cmd read");
        rdc(8'h20, 32'h0, "unmapped");
        setacc(8'h8F);
        exp_acc = 8'h00;
        cmd(OP_ADD_IMM, 1'b0, 3'h0, 7'h00, 9'h071, 1, 1'b0);
        rdc(`CABBO_ADR_STAT, 32'h7, "stat");
        setf(7'h05, 8'h3C);
        setacc(8'h0F);
        exp_acc = 8'h0C;
        cmd(OP_AND_FILE, 1'b0, 3'h0, 7'h05, 9'h0, 1, 1'b0);
        rdc(`CABBO_ADR_STAT, 32'h3, "stat");
        setacc(8'hC3);
        cmd(OP_AND_FILE, 1'b1, 3'h0, 7'h05, 9'h0, 1, 1'b0);
        chkf(7'h05, 8'h00);
        rdc(`CABBO_ADR_STAT, 32'h7, "stat");
        setf(7'h06, 8'h28);
        setacc(8'h19);
        cmd(OP_ADD_FILE, 1'b1, 3'h0, 7'h06, 9'h0, 1, 1'b0);
        chkf(7'h06, 8'h41);
        rdc(`CABBO_ADR_STAT, 32'h2, "stat");
        setacc(8'hBF);
        exp_acc = 8'h00;
        cmd(OP_ADD_FILE, 1'b0, 3'h0, 7'h06, 9'h0, 1, 1'b0);
        rdc(`CABBO_ADR_STAT, 32'h7, "stat");
        // the low nibbles make the half carry here even without the carry in
        wr(`CABBO_ADR_STAT, 32'h1);
        setacc(8'h0F);
        exp_acc = 8'h51;
        cmd(OP_ADDC_FILE, 1'b0, 3'h0, 7'h06, 9'h0, 1, 1'b0);
        rdc(`CABBO_ADR_STAT, 32'h2, "stat");
        setacc(8'hBF);
        cmd(OP_ADDC_FILE, 1'b1, 3'h0, 7'h06, 9'h0, 1, 1'b0);
        chkf(7'h06, 8'h00);
        rdc(`CABBO_ADR_STAT, 32'h7, "stat");
        setf(7'h07, 8'h81);
        wr(`CABBO_ADR_STAT, 32'h2);
        exp_acc = 8'hC0;
        cmd(OP_ASR_FILE, 1'b0, 3'h0, 7'h07, 9'h0, 1, 1'b0);
        chkf(7'h07, 8'h81);
        rdc(`CABBO_ADR_STAT, 32'h3, "stat");
        setf(7'h07, 8'h01);
        cmd(OP_ASR_FILE, 1'b1, 3'h0, 7'h07, 9'h0, 1, 1'b0);
        chkf(7'h07, 8'h00);
        rdc(`CABBO_ADR_STAT, 32'h7, "stat");
        setf(7'h09, 8'hFF);
        v = 8'hFF;
        for (int i = 0; i < 8; i++)
        begin
            v = v & ~(8'h01 << i);
            cmd(OP_CLR_BIT, i[0], i[2:0], 7'h09, 9'h0, 1, 1'b0);
            chkf(7'h09, v);
        end
        rdc(`CABBO_ADR_STAT, 32'h7, "stat");
        setf(7'h09, 8'h55);
        for (int i = 0; i < 8; i++)
            cmd(OP_TEST_SKIP_ZERO, 1'b0, i[2:0], 7'h09, 9'h0, 1 + i % 2, i[0]);
        rdc(`CABBO_ADR_STAT, 32'h7, "stat");
        cmd(OP_NOP, 1'b0, 3'h0, 7'h00, 9'h0, 1, 1'b0);
        wr(`CABBO_ADR_PC, 32'h100);
        exp_pc = 15'h100;
        // offsets kept inside the reachable window
        for (int i = 0; i < 4; i++)
            cmd(OP_REL_JUMP, 1'b0, 3'h0, 7'h00, 9'(offs[i]), 1 + offs[i], 1'b1);
        rdc(`CABBO_ADR_PC, {17'h0, exp_pc}, "pc");
        rdc(`CABBO_ADR_STAT, 32'h7, "stat");
        test_done;
    end
endmodule
`default_nettype wire
